//--- hw/tfl_defines.vh
// Register map, field positions and reset values of the tone and loop-back control block
`ifndef TFL_DEFINES_VH
`define TFL_DEFINES_VH

// Register byte offsets on the APB
`define TFL_ADDR_W 8
`define TFL_OFF_TONE_ONE_CTRL 8'h00
`define TFL_OFF_TONE_ONE_FREQ_LOW 8'h04
`define TFL_OFF_LOOPBACK_TEST_CONTROL 8'h08
`define TFL_OFF_FACTORY_TEST_RESERVED 8'h0c
`define TFL_OFF_STATUS 8'h10

// Reset values
`define TFL_RST_TONE_ONE_CTRL 8'h00
`define TFL_RST_TONE_ONE_FREQ_LOW 8'h00
`define TFL_RST_LOOPBACK_TEST_CONTROL 8'h00
`define TFL_RST_FACTORY_TEST_RESERVED 8'h00

// Tone control register fields
`define TFL_BIT_FREQ_MSB 0
`define TFL_BIT_RING_MODE 7

// Frequency word fields
`define TFL_FREQ_W 9
`define TFL_RING_W 6
`define TFL_HZ_W 12
`define TFL_FREQ_STEP_HZ 12'h00a

// Loop-back test control fields
`define TFL_CH2_LOOP_HI 7
`define TFL_CH2_LOOP_LO 6
`define TFL_CH1_LOOP_HI 5
`define TFL_CH1_LOOP_LO 4
`define TFL_FACTORY_BITS_HI 3

// Loop-back mode encodings
`define TFL_LOOP_OFF_A 2'h0
`define TFL_LOOP_OFF_B 2'h1
`define TFL_LOOP_DIGITAL 2'h2
`define TFL_LOOP_ANALOG 2'h3

// Status register fields
`define TFL_ST_HZ_LSB 0
`define TFL_ST_RING 12
`define TFL_ST_CH1_DIG 13
`define TFL_ST_CH1_ANA 14
`define TFL_ST_CH2_DIG 15
`define TFL_ST_CH2_ANA 16

// Default analog sample width
`define TFL_SAMPLE_W 14

`endif

//--- hw/tfl_loop_path.v
// One channel's loop-back path switch for the PCM and analog sample paths
`default_nettype none

module tfl_loop_path
#(
   parameter SAMPLE_W = 14
)
(
   // Clock and reset
   input wire clk_sys,
   input wire resetn,
   // Decoded loop-back mode
   input wire dig_loop_en,
   input wire ana_loop_en,
   // PCM side
   input wire tx_pcm_bit,
   input wire pcm_in_bit,
   output reg rx_pcm_bit,
   // Analog sample side
   input wire [SAMPLE_W-1:0] adc_sample,
   input wire [SAMPLE_W-1:0] dac_sample,
   output reg [SAMPLE_W-1:0] tx_sample,
   output reg ana_loop_active,
   output reg ana_in_ignore
);

   ////////////////////////////////////////////////////////////////////////
   // Receive PCM bit: own outgoing data replaces the serial input
   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         rx_pcm_bit <= 1'b0;
      end
      else if (dig_loop_en)
      begin
         // Serial input is dropped entirely while looping
         rx_pcm_bit <= tx_pcm_bit;
      end
      else
      begin
         rx_pcm_bit <= pcm_in_bit;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit sample: receive output fed back behind the input amplifier
   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         tx_sample <= {SAMPLE_W{1'b0}};
         ana_loop_active <= 1'b0;
         ana_in_ignore <= 1'b0;
      end
      else
      begin
         // Receive output itself is never gated, only the transmit input
         tx_sample <= ana_loop_en ? dac_sample : adc_sample;
         ana_loop_active <= ana_loop_en;
         ana_in_ignore <= ana_loop_en;
      end
   end

endmodule // tfl_loop_path

`default_nettype wire

//--- hw/tfl_ctrl.v
// Tone generator one frequency and loop-back test control registers with APB access
`include "tfl_defines.vh"
`default_nettype none

module tfl_ctrl
#(
   parameter SAMPLE_W = `TFL_SAMPLE_W
)
(
   // Clock and reset
   input wire clk_sys,
   input wire resetn,
   // APB slave
   input wire [`TFL_ADDR_W-1:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg pready,
   output reg [31:0] prdata,
   output reg pslverr,
   // PCM serial highway pins
   input wire pcm_serial_in,
   output reg pcm_serial_out,
   // Codec PCM bit streams, one bit per channel
   input wire [1:0] tx_pcm_bit,
   input wire pcm_slot_ch2,
   output wire [1:0] rx_pcm_bit,
   // Codec analog sample paths, channel 1 in the low half
   input wire [2*SAMPLE_W-1:0] adc_sample,
   input wire [2*SAMPLE_W-1:0] dac_sample,
   output wire [2*SAMPLE_W-1:0] tx_sample,
   output wire [1:0] ana_loop_active,
   output wire [1:0] ana_in_ignore,
   // Tone generator one settings
   output reg ch2_ring_mode_select,
   output reg [`TFL_FREQ_W-1:0] tone_one_freq_code,
   output reg [`TFL_HZ_W-1:0] tone_one_freq_hz
);

   ////////////////////////////////////////////////////////////////////////
   // Decoding helpers

   // Loop-back field decode: bit 0 is digital, bit 1 is analog
   // A one-hot result keeps the two loop modes exclusive by construction.
   // Both off codes share the default branch, so no reserved code can loop.
   function [1:0] loop_decode;
      input [1:0] sel;
      begin
         case (sel)
            `TFL_LOOP_DIGITAL: loop_decode = 2'h1;
            `TFL_LOOP_ANALOG: loop_decode = 2'h2;
            default: loop_decode = 2'h0;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register storage
   // All four registers are plain bytes; only the status word is derived.
   reg [7:0] tone_one_ctrl_q; // Frequency msb and ring mode
   reg [7:0] tone_one_freq_low_q; // Lower eight bits of frequency word
   reg [7:0] loopback_test_control_q; // Loop selects and factory bits
   reg [7:0] factory_test_reserved_q; // Factory-only bits, no effect here
   reg [1:0] pcm_in_sync_q; // Serial input synchroniser

   // Bus decode
   // An access edge with pready low asks for the answer; with it high, commits.
   wire setup_access = psel & penable & ~pready;
   wire commit = psel & penable & pready;
   wire wr_commit = commit & pwrite;
   reg [31:0] rd_mux;
   reg addr_hit;

   // Effective frequency words
   // Ring mode picks between two readings of the same register pair.
   wire ring_sel = tone_one_ctrl_q[`TFL_BIT_RING_MODE];
   wire [`TFL_FREQ_W-1:0] voice_code;
   wire [`TFL_FREQ_W-1:0] ring_code;
   wire [`TFL_FREQ_W-1:0] eff_code;
   wire [`TFL_HZ_W-1:0] voice_hz;
   wire [`TFL_HZ_W-1:0] eff_hz;

   // Decoded loop-back enables, index 0 is channel 1
   // Index 1 is channel 2; both come from the same decode function.
   wire [1:0] dig_loop;
   wire [1:0] ana_loop;
   wire [1:0] loop_field [0:1];

   ////////////////////////////////////////////////////////////////////////
   // Read data and address decode
   // Upper data bits read as zero; each stored register is one byte in its own word, status fills bits 16:0.
   // Status hertz field follows a write one cycle late, loop flags at once.
   always @*
   begin
      rd_mux = 32'h0000_0000;
      addr_hit = 1'b1;
      case (paddr)
         `TFL_OFF_TONE_ONE_CTRL: rd_mux[7:0] = tone_one_ctrl_q;
         `TFL_OFF_TONE_ONE_FREQ_LOW: rd_mux[7:0] = tone_one_freq_low_q;
         `TFL_OFF_LOOPBACK_TEST_CONTROL: rd_mux[7:0] = loopback_test_control_q;
         `TFL_OFF_FACTORY_TEST_RESERVED: rd_mux[7:0] = factory_test_reserved_q;
         `TFL_OFF_STATUS:
         begin
            // Live view of what the block is actually applying
            rd_mux[`TFL_ST_HZ_LSB+`TFL_HZ_W-1:`TFL_ST_HZ_LSB] = tone_one_freq_hz;
            rd_mux[`TFL_ST_RING] = ch2_ring_mode_select;
            rd_mux[`TFL_ST_CH1_DIG] = dig_loop[0];
            rd_mux[`TFL_ST_CH1_ANA] = ana_loop[0];
            rd_mux[`TFL_ST_CH2_DIG] = dig_loop[1];
            rd_mux[`TFL_ST_CH2_ANA] = ana_loop[1];
         end
         default:
         begin
            // Unmapped: zero data with an error answer
            addr_hit = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // APB answer: one wait state, then pready for exactly one cycle
   // The first access edge registers the answer, the second completes it.
   // Trading one cycle per access for clean flop outputs costs nothing here,
   // as the host touches these registers only when it changes a setting.
   // Read data returns to zero outside the answer cycle, so stale data never shows.
   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (setup_access)
      begin
         // Answer registered so that every bus output leaves a flop
         pready <= 1'b1;
         prdata <= pwrite ? 32'h0000_0000 : rd_mux;
         pslverr <= ~addr_hit;
      end
      else
      begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register writes, taken only at the edge where pready is sampled
   // Writing there, not at the first access edge, keeps the registers in step
   // with the master's view: a transfer abandoned before completion writes nothing.
   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         tone_one_ctrl_q <= `TFL_RST_TONE_ONE_CTRL;
         tone_one_freq_low_q <= `TFL_RST_TONE_ONE_FREQ_LOW;
         loopback_test_control_q <= `TFL_RST_LOOPBACK_TEST_CONTROL;
         factory_test_reserved_q <= `TFL_RST_FACTORY_TEST_RESERVED;
      end
      else if (wr_commit)
      begin
         case (paddr)
            `TFL_OFF_TONE_ONE_CTRL: tone_one_ctrl_q <= pwdata[7:0];
            `TFL_OFF_TONE_ONE_FREQ_LOW: tone_one_freq_low_q <= pwdata[7:0];
            // Factory bits are stored as written; they steer nothing here
            `TFL_OFF_LOOPBACK_TEST_CONTROL: loopback_test_control_q <= pwdata[7:0];
            // Kept only so a stray access is harmless
            `TFL_OFF_FACTORY_TEST_RESERVED: factory_test_reserved_q <= pwdata[7:0];
            default:
            begin
               // Status and unmapped offsets ignore writes
               tone_one_ctrl_q <= tone_one_ctrl_q;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Tone generator one frequency selection

   // Voice band: msb from the control register, low byte below it
   // The msb sits alone in bit 0 of the control register; the ring-mode bit is bit 7.
   assign voice_code = {tone_one_ctrl_q[`TFL_BIT_FREQ_MSB], tone_one_freq_low_q};
   // Code times ten, as shift-and-add to avoid a multiplier
   // Eight times the code plus twice the code, both terms 12 bits wide.
   // Limitation: a code above 409 no longer fits and its hertz value wraps.
   // Such a code lies far outside the voice band, so no clamp is spent on it.
   assign voice_hz = {voice_code, 3'h0} + {2'h0, voice_code, 1'h0};
   // Ringing: upper three bits dropped, six-bit field alone
   assign ring_code = {3'h0, tone_one_freq_low_q[`TFL_RING_W-1:0]};
   assign eff_code = ring_sel ? ring_code : voice_code;
   // Ringing code is the frequency in hertz, 1 Hz steps
   assign eff_hz = ring_sel ? {3'h0, ring_code} : voice_hz;

   // Out-of-band words are passed on unchanged; range is the host's job
   // Registering the tone outputs makes them change one cycle after a write,
   // with code, hertz and ring flag always updated together.
   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         ch2_ring_mode_select <= 1'b0;
         tone_one_freq_code <= {`TFL_FREQ_W{1'b0}};
         tone_one_freq_hz <= {`TFL_HZ_W{1'b0}};
      end
      else
      begin
         ch2_ring_mode_select <= ring_sel;
         tone_one_freq_code <= eff_code;
         tone_one_freq_hz <= eff_hz;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // PCM serial highway

   // Serial input crosses from the highway clock: two flops first
   // The input reaches the receive bit three cycles after the pin, one cycle
   // for each synchroniser flop and one for the path switch.
   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         pcm_in_sync_q <= 2'h0;
      end
      else
      begin
         pcm_in_sync_q <= {pcm_in_sync_q[0], pcm_serial_in};
      end
   end

   // Output keeps running in every loop-back mode
   // The slot select picks which channel owns the shared output one cycle later;
   // loop-back never gates it, so the far end still sees outgoing data.
   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         pcm_serial_out <= 1'b0;
      end
      else
      begin
         pcm_serial_out <= pcm_slot_ch2 ? tx_pcm_bit[1] : tx_pcm_bit[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-channel loop-back decode and path switch
   // Both channels share one synchronised serial input; a channel in digital
   // loop-back simply stops listening to it and hears its own outgoing bit.

   // Channel 1 field in bits 5:4, channel 2 in bits 7:6
   assign loop_field[0] = loopback_test_control_q[`TFL_CH1_LOOP_HI:`TFL_CH1_LOOP_LO];
   assign loop_field[1] = loopback_test_control_q[`TFL_CH2_LOOP_HI:`TFL_CH2_LOOP_LO];

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1)
      begin : g_chan
         wire [1:0] mode;
         // Both 00 and 01 mean loop-back off
         assign mode = loop_decode(loop_field[ch]);
         assign dig_loop[ch] = mode[0];
         assign ana_loop[ch] = mode[1];

         // Digital loop analog loop
         tfl_loop_path #(
            .SAMPLE_W(SAMPLE_W)
         ) u_path (
            .clk_sys(clk_sys),
            .resetn(resetn),
            .dig_loop_en(dig_loop[ch]),
            .ana_loop_en(ana_loop[ch]),
            .tx_pcm_bit(tx_pcm_bit[ch]),
            .pcm_in_bit(pcm_in_sync_q[1]),
            .rx_pcm_bit(rx_pcm_bit[ch]),
            .adc_sample(adc_sample[ch*SAMPLE_W +: SAMPLE_W]),
            .dac_sample(dac_sample[ch*SAMPLE_W +: SAMPLE_W]),
            .tx_sample(tx_sample[ch*SAMPLE_W +: SAMPLE_W]),
            .ana_loop_active(ana_loop_active[ch]),
            .ana_in_ignore(ana_in_ignore[ch])
         );
      end
   endgenerate

endmodule // tfl_ctrl

`default_nettype wire

//--- testbench/tfl_ctrl_sva.sv
// Port-level assertions for the tone and loop-back control block
`default_nettype none
module tfl_ctrl_sva (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Register bus
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // PCM and loop-back
   input wire logic pcm_serial_out,
   input wire logic [1:0] tx_pcm_bit,
   input wire logic pcm_slot_ch2,
   input wire logic [1:0] ana_loop_active,
   input wire logic [1:0] ana_in_ignore,
   // Tone settings
   input wire logic ch2_ring_mode_select,
   input wire logic [8:0] tone_one_freq_code,
   input wire logic [11:0] tone_one_freq_hz
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // Address hits one of the five words
   logic mapped;
   assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held past one cycle");
   a_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("ready not after one wait state");
   a_err_unmapped: assert property (pready |-> pslverr == !mapped)
      else $error("error flag wrong for address");
   a_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
      else $error("read bus not quiet when idle");
   a_voice_scale:
      assert property (!ch2_ring_mode_select |->
         tone_one_freq_hz == {3'h0, tone_one_freq_code} * 12'h00a)
      else $error("voice frequency not ten hertz steps");
   a_ring_field:
      assert property (ch2_ring_mode_select |-> tone_one_freq_code[8:6] == 3'h0
         && tone_one_freq_hz == {6'h0, tone_one_freq_code[5:0]})
      else $error("ringing frequency not six-bit hertz");
   a_pcm_out_kept:
      assert property (1'b1 |=> pcm_serial_out == $past(tx_pcm_bit[pcm_slot_ch2]))
      else $error("serial output disturbed");
   a_ana_flags_pair:
      assert property (ana_in_ignore == ana_loop_active)
      else $error("analog ignore differs from loop flag");
   // Main scenarios reached
   c_ring: cover property (ch2_ring_mode_select);
   c_ana: cover property (ana_loop_active == 2'h3);
   c_err: cover property (pready && pslverr);
endmodule // tfl_ctrl_sva
`default_nettype wire

//--- testbench/tfl_pcm_far.sv
// Codec and PCM highway stand-in feeding the block's data paths
`default_nettype none
module tfl_pcm_far #(
   parameter int SAMPLE_W = 14
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Streams toward the block
   output wire logic pcm_serial_in,
   output wire logic [1:0] tx_pcm_bit,
   output wire logic pcm_slot_ch2,
   output wire logic [2*SAMPLE_W-1:0] adc_sample,
   output wire logic [2*SAMPLE_W-1:0] dac_sample
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt_q;
   // One clock times both directions, so loop-back frames line up
   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         cnt_q <= 8'h00;
      else
         cnt_q <= cnt_q + 8'h01;
   end
   // Serial input and upper sample bits flip each cycle, other lines every few, so a stale or crossed path shows; sample bit 0 is constant
   assign tx_pcm_bit = cnt_q[1:0] ^ cnt_q[3:2];
   assign pcm_serial_in = ~cnt_q[0];
   assign pcm_slot_ch2 = cnt_q[2];
   assign dac_sample = {2*SAMPLE_W{cnt_q[0]}} ^ {{(2*SAMPLE_W-8){1'b0}}, cnt_q};
   assign adc_sample = ~dac_sample;
endmodule // tfl_pcm_far
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for the tone and loop-back control block
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int W = 14;
   logic clk_sys = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   wire logic pready, pslverr, pcm_serial_out, ch2_ring_mode_select;
   wire logic pcm_serial_in, pcm_slot_ch2;
   wire logic [31:0] prdata;
   wire logic [1:0] rx_pcm_bit, ana_loop_active, ana_in_ignore, tx_pcm_bit;
   wire logic [2*W-1:0] tx_sample, adc_sample, dac_sample;
   wire logic [8:0] tone_one_freq_code;
   wire logic [11:0] tone_one_freq_hz;
   int err_count = 0, n_compared = 0, cycles = 0;
   tfl_ctrl #(
      .SAMPLE_W(W)
   ) i_tfl_ctrl (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .paddr(paddr),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .pwdata(pwdata),
      .pready(pready),
      .prdata(prdata),
      .pslverr(pslverr),
      .pcm_serial_in(pcm_serial_in),
      .pcm_serial_out(pcm_serial_out),
      .tx_pcm_bit(tx_pcm_bit),
      .pcm_slot_ch2(pcm_slot_ch2),
      .rx_pcm_bit(rx_pcm_bit),
      .adc_sample(adc_sample),
      .dac_sample(dac_sample),
      .tx_sample(tx_sample),
      .ana_loop_active(ana_loop_active),
      .ana_in_ignore(ana_in_ignore),
      .ch2_ring_mode_select(ch2_ring_mode_select),
      .tone_one_freq_code(tone_one_freq_code),
      .tone_one_freq_hz(tone_one_freq_hz)
   );
   tfl_pcm_far #(
      .SAMPLE_W(W)
   ) i_tfl_pcm_far (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .pcm_serial_in(pcm_serial_in),
      .tx_pcm_bit(tx_pcm_bit),
      .pcm_slot_ch2(pcm_slot_ch2),
      .adc_sample(adc_sample),
      .dac_sample(dac_sample)
   );
   always #12.5 clk_sys = ~clk_sys;
   // Cut a hang short
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         err_count++;
         complete_run();
      end
   end
   task automatic check(input logic [31:0] seen, exp, input string what);
      n_compared++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One bus transfer: setup, access, hold until ready is sampled
   task automatic apb(input [7:0] a, input w, input [31:0] d, output [31:0] r, output e);
      @(posedge clk_sys);
      psel <= 1;
      penable <= 0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic wr(input [7:0] a, input [7:0] d);
      logic [31:0] r;
      logic e;
      apb(a, 1, {24'h0, d}, r, e);
   endtask
   task automatic rd(input [7:0] a, input [31:0] x, input xe);
      logic [31:0] r;
      logic e;
      apb(a, 0, 32'h0, r, e);
      check(r, x, "read data");
      check(e, xe, "error flag");
   endtask
   task automatic settle();
      repeat (2) @(posedge clk_sys);
      #1;
   endtask
   // Reset values, then an unmapped word; the factory word is left alone
   task automatic t_reset();
      for (int i = 0; i < 3; i++) rd(8'(i * 4), 32'h0, 0);
      rd(8'h14, 32'h0, 1);
   endtask
   // Voice-band words, all kept inside the band
   task automatic t_voice();
      logic [8:0] c[4] = '{9'h01e, 9'h096, 9'h12c, 9'h154};
      foreach (c[i])
      begin
         wr(8'h00, {7'h0, c[i][8]});
         wr(8'h04, c[i][7:0]);
         settle();
         check(tone_one_freq_code, c[i], "code");
         check(tone_one_freq_hz, c[i] * 10, "hertz");
         check(ch2_ring_mode_select, 0, "ring select");
         rd(8'h04, c[i][7:0], 0);
         rd(8'h10, c[i] * 10, 0);
      end
   endtask
   // Ringing mode with junk in the ignored upper bits
   task automatic t_ring();
      logic [5:0] f[3] = '{6'h0f, 6'h14, 6'h32};
      foreach (f[i])
      begin
         wr(8'h00, 8'h81);
         wr(8'h04, {2'b11, f[i]});
         settle();
         check(tone_one_freq_code, f[i], "ring code");
         check(tone_one_freq_hz, f[i], "ring hertz");
         check(ch2_ring_mode_select, 1, "ring select");
         rd(8'h10, 32'h1000 | f[i], 0);
      end
      wr(8'h00, 8'h00);
      wr(8'h04, 8'h00);
   endtask
   // Every select code on both channels, factory bits kept zero
   task automatic t_loop();
      logic [7:0] v[6] = '{8'h00, 8'h50, 8'h80, 8'hb0, 8'he0, 8'hf0};
      logic [1:0] t;
      logic [2*W-1:0] s, c;
      logic d2, a2, d1, a1;
      logic p, sl;
      foreach (v[i])
      begin
         wr(8'h08, v[i]);
         d2 = v[i][7:6] == 2'h2;
         a2 = v[i][7:6] == 2'h3;
         d1 = v[i][5:4] == 2'h2;
         a1 = v[i][5:4] == 2'h3;
         settle();
         @(posedge clk_sys);
         t = tx_pcm_bit;
         s = dac_sample;
         c = adc_sample;
         // Pin toggles every cycle, so its value now equals the synchronised one
         p = pcm_serial_in;
         sl = pcm_slot_ch2;
         #1;
         check(ana_loop_active, {a2, a1}, "analog loop");
         check(ana_in_ignore, {a2, a1}, "analog input ignored");
         check(pcm_serial_out, t[sl], "serial output");
         if (d2) check(rx_pcm_bit[1], t[1], "ch2 digital loop");
         if (d1) check(rx_pcm_bit[0], t[0], "ch1 digital loop");
         if (!d2) check(rx_pcm_bit[1], p, "ch2 receive from pin");
         if (!d1) check(rx_pcm_bit[0], p, "ch1 receive from pin");
         check(tx_sample, {a2 ? s[2*W-1:W] : c[2*W-1:W], a1 ? s[W-1:0] : c[W-1:0]},
            "transmit sample");
         rd(8'h08, v[i], 0);
         rd(8'h10, {15'h0, a2, d2, a1, d1, 13'h0}, 0);
      end
   endtask
   task automatic complete_run();
      $display("compared %0d mismatched %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      repeat (16) @(posedge clk_sys);
      resetn <= 1;
      t_reset();
      t_voice();
      t_ring();
      t_loop();
      complete_run();
   end
endmodule // tb_top
bind tfl_ctrl tfl_ctrl_sva i_tfl_ctrl_sva (
   .clk_sys(clk_sys),
   .resetn(resetn),
   .paddr(paddr),
   .psel(psel),
   .penable(penable),
   .pready(pready),
   .prdata(prdata),
   .pslverr(pslverr),
   .pcm_serial_out(pcm_serial_out),
   .tx_pcm_bit(tx_pcm_bit),
   .pcm_slot_ch2(pcm_slot_ch2),
   .ana_loop_active(ana_loop_active),
   .ana_in_ignore(ana_in_ignore),
   .ch2_ring_mode_select(ch2_ring_mode_select),
   .tone_one_freq_code(tone_one_freq_code),
   .tone_one_freq_hz(tone_one_freq_hz)
);
`default_nettype wire
